/* File: aplc_device.sv */
`default_nettype none
// Overview of operation
// RULE1 - host drives master clock at nominal rate
// RULE2 - doubled master clock needs doubling bit set
// RULE3 - crystal mode hides internal clock from drive
// RULE4 - serial port acts only while select low
// RULE5 - select tied low gives three-wire port
// RULE6 - select falling edge frames each transfer
// RULE7 - reset pin low restores power-on state
// RULE8 - reset exit needs pin high, clock toggling
// RULE9 - aux input one lands in bit four
// RULE10 - aux input zero lands in bit three
// RULE11 - differential pairs one-two, three-four, five-six
// RULE12 - pseudo-differential inputs one-five against six
// RULE13 - aux inputs latched on first read fall
// RULE14 - tied-low select requires clock idling high
// RULE15 - interrupt low on new word, high after read
// RULE16 - reset release aligned to master clock edge
module aplc_device
    import aplc_pkg::*;
#(
    parameter int DATA_W = WORD_W
) (
    input  wire logic              clk,
    input  wire logic              rst,
    aplc_if.dev                    link,
    input  wire logic              crystalMode,
    input  wire logic              diffMode,
    input  wire logic [CH_W-1:0]   chanSel,
    input  wire logic [DATA_W-1:0] dataIn,
    input  wire logic              dataValid,
    output logic                   dataReady,
    output logic [NUM_AIN-1:0]     posSel,
    output logic [NUM_AIN-1:0]     negSel,
    output logic [CMD_W-1:0]       cmdByte,
    output logic                   cmdValid,
    output logic                   modTick,
    output logic                   coreReset
);
    localparam int BC_W = $clog2(DATA_W + 1);

    initial begin
        if (DATA_W <= AUX1_BIT) $error("DATA_W too small for aux bits");
    end

    function automatic logic [2*NUM_AIN-1:0] muxSel(input logic diff,
                                                    input logic [CH_W-1:0] ch);
        logic [NUM_AIN-1:0] p;
        logic [NUM_AIN-1:0] n;
        p = '0;
        n = '0;
        if (diff && ch < CH_W'(DIFF_CHANS)) begin
            p[2*ch]     = 1'b1; // RULE11
            n[2*ch + 1] = 1'b1; // RULE11
        end else if (!diff && ch < CH_W'(PSEUDO_CHANS)) begin
            p[ch]         = 1'b1; // RULE12
            n[COMMON_AIN] = 1'b1; // RULE12
        end
        return {p, n};
    endfunction

    logic [PIN_N-1:0] pinS1_reg;
    logic [PIN_N-1:0] pinS2_reg;
    logic [PIN_N-1:0] pinS3_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pinS1_reg <= 8'hEE;
            pinS2_reg <= 8'hEE;
            pinS3_reg <= 8'hEE;
        end else begin
            pinS1_reg <= {link.clockDoubleSel, link.auxStatusIn1, link.auxStatusIn0,
                          link.resetN, link.din, link.sclk, link.csN, link.masterClock};
            pinS2_reg <= pinS1_reg;
            pinS3_reg <= pinS2_reg;
        end
    end

    logic              coreRst_reg, coreRst_next;
    logic              mclkDiv_reg, mclkDiv_next;
    logic              modTick_reg, modTick_next;
    logic [DATA_W-1:0] mem_reg [FIFO_DEPTH];
    logic [DATA_W-1:0] mem_next [FIFO_DEPTH];
    logic              wrPtr_reg, wrPtr_next;
    logic              rdPtr_reg, rdPtr_next;
    logic [1:0]        count_reg, count_next;
    logic              dataReady_reg, dataReady_next;
    logic [DATA_W-1:0] hold_reg, hold_next;
    logic [DATA_W-1:0] shift_reg, shift_next;
    logic              wordPend_reg, wordPend_next;
    logic              intN_reg, intN_next;
    logic              auxTaken_reg, auxTaken_next;
    logic [BC_W-1:0]   bitCnt_reg, bitCnt_next;
    logic              invPol_reg, invPol_next;
    logic              dout_reg, dout_next;
    logic              doutOe_reg, doutOe_next;
    logic [CMD_W-1:0]  rxSh_reg, rxSh_next;
    logic [2:0]        rxCnt_reg, rxCnt_next;
    logic [CMD_W-1:0]  cmdByte_reg, cmdByte_next;
    logic              cmdValid_reg, cmdValid_next;
    logic              xtal_reg, xtal_next;
    logic [2*NUM_AIN-1:0] sel_reg, sel_next;

    logic mclkRise, csLow, csFall, sclkFall, sclkRise, push, pop;
    logic [DATA_W-1:0] word;

    always_comb begin
        mclkRise = pinS2_reg[PIN_MCLK] & ~pinS3_reg[PIN_MCLK];
        csLow    = ~pinS2_reg[PIN_CSN]; // RULE4
        csFall   = csLow & pinS3_reg[PIN_CSN];
        // polarity is only changed by a select fall or core reset, so both samples agree
        sclkFall = ~(pinS2_reg[PIN_SCLK] ^ invPol_reg) & (pinS3_reg[PIN_SCLK] ^ invPol_reg);
        sclkRise = (pinS2_reg[PIN_SCLK] ^ invPol_reg) & ~(pinS3_reg[PIN_SCLK] ^ invPol_reg);
        push     = dataValid & dataReady_reg;
        pop      = modTick_reg & (count_reg != 2'h0) & ~wordPend_reg & ~auxTaken_reg;
        word     = hold_reg;
        word[AUX1_BIT] = pinS2_reg[PIN_AUX1]; // RULE9
        word[AUX0_BIT] = pinS2_reg[PIN_AUX0]; // RULE10

        coreRst_next = coreRst_reg;
        if (!pinS2_reg[PIN_RSTN]) begin
            coreRst_next = 1'b1; // RULE7
        end else if (mclkRise) begin
            coreRst_next = 1'b0; // RULE8 RULE16
        end

        // with doubling on, every second master rising edge feeds the modulator
        mclkDiv_next = mclkRise ? (pinS2_reg[PIN_DBL] & ~mclkDiv_reg) : mclkDiv_reg;
        modTick_next = mclkRise & (~pinS2_reg[PIN_DBL] | mclkDiv_reg); // RULE2

        mem_next   = mem_reg;
        wrPtr_next = wrPtr_reg;
        rdPtr_next = rdPtr_reg;
        if (push) begin
            mem_next[wrPtr_reg] = dataIn;
            wrPtr_next = ~wrPtr_reg;
        end
        if (pop) begin
            rdPtr_next = ~rdPtr_reg;
        end
        count_next     = count_reg + {1'b0, push} - {1'b0, pop};
        dataReady_next = count_next != 2'(FIFO_DEPTH);

        hold_next     = pop ? mem_reg[rdPtr_reg] : hold_reg;
        shift_next    = shift_reg;
        wordPend_next = wordPend_reg | pop;
        intN_next     = intN_reg & ~pop; // RULE15
        auxTaken_next = auxTaken_reg;
        bitCnt_next   = bitCnt_reg;
        invPol_next   = csFall ? ~pinS2_reg[PIN_SCLK] : invPol_reg; // RULE6 RULE14
        dout_next     = dout_reg;
        doutOe_next   = csLow;
        rxSh_next     = rxSh_reg;
        rxCnt_next    = rxCnt_reg;
        cmdByte_next  = cmdByte_reg;
        cmdValid_next = 1'b0;

        if (!csLow) begin
            // select high ends any partial frame; a cut read restarts whole
            auxTaken_next = 1'b0; // RULE6
            bitCnt_next   = '0;
            rxCnt_next    = 3'h0;
        end else if (wordPend_reg) begin
            if (sclkFall) begin
                if (!auxTaken_reg) begin
                    dout_next     = word[DATA_W-1]; // RULE13
                    shift_next    = {word[DATA_W-2:0], 1'b0};
                    auxTaken_next = 1'b1;
                end else begin
                    dout_next  = shift_reg[DATA_W-1];
                    shift_next = {shift_reg[DATA_W-2:0], 1'b0};
                end
            end
            if (sclkRise && auxTaken_reg) begin
                bitCnt_next = bitCnt_reg + BC_W'(1);
                if (bitCnt_reg == BC_W'(DATA_W - 1)) begin
                    wordPend_next = 1'b0;
                    intN_next     = 1'b1; // RULE15
                    auxTaken_next = 1'b0;
                    bitCnt_next   = '0;
                end
            end
        end else if (sclkRise) begin
            rxSh_next  = {rxSh_reg[CMD_W-2:0], pinS2_reg[PIN_DIN]}; // RULE5
            rxCnt_next = rxCnt_reg + 3'h1;
            if (rxCnt_reg == 3'(CMD_W - 1)) begin
                cmdByte_next  = {rxSh_reg[CMD_W-2:0], pinS2_reg[PIN_DIN]};
                cmdValid_next = 1'b1;
            end
        end

        // the drive pin only inverts the input, it never carries the core clock
        xtal_next = crystalMode & ~pinS2_reg[PIN_MCLK]; // RULE3
        sel_next  = muxSel(diffMode, chanSel);

        if (coreRst_reg) begin
            mclkDiv_next   = 1'b0; // RULE7
            modTick_next   = 1'b0;
            wrPtr_next     = 1'b0;
            rdPtr_next     = 1'b0;
            count_next     = 2'h0;
            dataReady_next = 1'b0;
            wordPend_next  = 1'b0;
            intN_next      = 1'b1;
            auxTaken_next  = 1'b0;
            bitCnt_next    = '0;
            invPol_next    = 1'b0;
            dout_next      = 1'b0;
            doutOe_next    = 1'b0;
            rxCnt_next     = 3'h0;
            cmdValid_next  = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            coreRst_reg   <= 1'b1;
            mclkDiv_reg   <= 1'b0;
            modTick_reg   <= 1'b0;
            mem_reg       <= '{default: '0};
            wrPtr_reg     <= 1'b0;
            rdPtr_reg     <= 1'b0;
            count_reg     <= 2'h0;
            dataReady_reg <= 1'b0;
            hold_reg      <= '0;
            shift_reg     <= '0;
            wordPend_reg  <= 1'b0;
            intN_reg      <= 1'b1;
            auxTaken_reg  <= 1'b0;
            bitCnt_reg    <= '0;
            invPol_reg    <= 1'b0;
            dout_reg      <= 1'b0;
            doutOe_reg    <= 1'b0;
            rxSh_reg      <= 8'h00;
            rxCnt_reg     <= 3'h0;
            cmdByte_reg   <= 8'h00;
            cmdValid_reg  <= 1'b0;
            xtal_reg      <= 1'b0;
            sel_reg       <= 12'h000;
        end else begin
            coreRst_reg   <= coreRst_next;
            mclkDiv_reg   <= mclkDiv_next;
            modTick_reg   <= modTick_next;
            mem_reg       <= mem_next;
            wrPtr_reg     <= wrPtr_next;
            rdPtr_reg     <= rdPtr_next;
            count_reg     <= count_next;
            dataReady_reg <= dataReady_next;
            hold_reg      <= hold_next;
            shift_reg     <= shift_next;
            wordPend_reg  <= wordPend_next;
            intN_reg      <= intN_next;
            auxTaken_reg  <= auxTaken_next;
            bitCnt_reg    <= bitCnt_next;
            invPol_reg    <= invPol_next;
            dout_reg      <= dout_next;
            doutOe_reg    <= doutOe_next;
            rxSh_reg      <= rxSh_next;
            rxCnt_reg     <= rxCnt_next;
            cmdByte_reg   <= cmdByte_next;
            cmdValid_reg  <= cmdValid_next;
            xtal_reg      <= xtal_next;
            sel_reg       <= sel_next;
        end
    end

    assign link.crystalDriveOut = xtal_reg;
    assign link.dout            = dout_reg;
    assign link.doutOe          = doutOe_reg;
    assign link.intN            = intN_reg;
    assign dataReady            = dataReady_reg;
    assign posSel               = sel_reg[2*NUM_AIN-1:NUM_AIN];
    assign negSel               = sel_reg[NUM_AIN-1:0];
    assign cmdByte              = cmdByte_reg;
    assign cmdValid             = cmdValid_reg;
    assign modTick              = modTick_reg;
    assign coreReset            = coreRst_reg;
endmodule
`default_nettype wire

/* File: aplc_pkg.sv */
`default_nettype none
package aplc_pkg;
    localparam int CLK_HZ          = 40000000;
    localparam int CLK_MHZ         = 40;
    localparam int WORD_W          = 16;
    localparam int CMD_W           = 8;
    localparam int AUX1_BIT        = 4;
    localparam int AUX0_BIT        = 3;
    localparam int NUM_AIN         = 6;
    localparam int CH_W            = 3;
    localparam int DIFF_CHANS      = 3;
    localparam int PSEUDO_CHANS    = 5;
    localparam int COMMON_AIN      = 5;
    localparam int MCLK_NOM_HI_HZ  = 2457600;
    localparam int MCLK_NOM_LO_HZ  = 1024000;
    localparam int MCLK_DBL_HI_HZ  = 2 * MCLK_NOM_HI_HZ;
    localparam int MCLK_DBL_LO_HZ  = 2 * MCLK_NOM_LO_HZ;
    // longest half period that still reaches the nominal rate, rounded down
    localparam int MCLK_HALF_CYC   = CLK_HZ / (2 * MCLK_NOM_HI_HZ);
    localparam int SCLK_MIN_NS     = 100;
    localparam int SCLK_HALF_CYC   = (SCLK_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int FIFO_DEPTH      = 2;
    // pin vector positions inside the device synchroniser
    localparam int PIN_MCLK        = 0;
    localparam int PIN_CSN         = 1;
    localparam int PIN_SCLK        = 2;
    localparam int PIN_DIN         = 3;
    localparam int PIN_RSTN        = 4;
    localparam int PIN_AUX0        = 5;
    localparam int PIN_AUX1        = 6;
    localparam int PIN_DBL         = 7;
    localparam int PIN_N           = 8;
endpackage
`default_nettype wire

/* File: aplc_if.sv */
`default_nettype none
interface aplc_if;
    logic masterClock;
    logic crystalDriveOut;
    logic clockDoubleSel;
    logic csN;
    logic sclk;
    logic din;
    logic dout;
    logic doutOe;
    logic doutLine;
    logic intN;
    logic resetN;
    logic auxStatusIn0;
    logic auxStatusIn1;
    // released data line is pulled high
    assign doutLine = doutOe ? dout : 1'b1;
    modport dev (input masterClock, clockDoubleSel, csN, sclk, din, resetN,
                 auxStatusIn0, auxStatusIn1,
                 output crystalDriveOut, dout, doutOe, intN);
    modport host (output masterClock, clockDoubleSel, csN, sclk, din, resetN,
                  auxStatusIn0, auxStatusIn1,
                  input crystalDriveOut, doutLine, intN);
endinterface
`default_nettype wire

/* File: aplc_host.sv */
`default_nettype none
module aplc_host
    import aplc_pkg::*;
#(
    parameter int SCLK_HALF = SCLK_HALF_CYC,
    parameter int MCLK_HALF = MCLK_HALF_CYC
) (
    input  wire logic              clk,
    input  wire logic              rst,
    aplc_if.host                   link,
    input  wire logic              resetReq,
    input  wire logic              dblClock,
    input  wire logic              aux0In,
    input  wire logic              aux1In,
    input  wire logic              readReq,
    input  wire logic              writeReq,
    input  wire logic [CMD_W-1:0]  writeByte,
    output logic                   busy,
    output logic                   wordPending,
    output logic [WORD_W-1:0]      wordOut,
    output logic                   wordValid
);
    initial begin
        if (SCLK_HALF < SCLK_HALF_CYC) $error("SCLK_HALF below serial clock minimum");
        if (MCLK_HALF < 1) $error("MCLK_HALF must be at least 1");
    end

    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_LOW, H_HIGH, H_END} aplc_hstate_e;

    logic [1:0] intS_reg;
    logic [1:0] doutS_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            intS_reg  <= 2'h3;
            doutS_reg <= 2'h3;
        end else begin
            intS_reg  <= {intS_reg[0], link.intN};
            doutS_reg <= {doutS_reg[0], link.doutLine};
        end
    end

    aplc_hstate_e     st_reg, st_next;
    logic [7:0]       tmr_reg, tmr_next;
    logic [7:0]       mcnt_reg, mcnt_next;
    logic             mclk_reg, mclk_next;
    logic [4:0]       bit_reg, bit_next;
    logic             isRead_reg, isRead_next;
    logic             csN_reg, csN_next;
    logic             sclk_reg, sclk_next;
    logic             din_reg, din_next;
    logic [CMD_W-1:0] tx_reg, tx_next;
    logic [WORD_W-1:0] rx_reg, rx_next;
    logic             valid_reg, valid_next;
    logic             rstN_reg, rstN_next;
    logic [2:0]       pins_reg, pins_next;
    logic             pend;

    always_comb begin
        pend        = ~intS_reg[1];
        // the master clock never stops, so reset release always sees edges
        mcnt_next   = mcnt_reg + 8'h01; // RULE8
        mclk_next   = mclk_reg;
        if (mcnt_reg == 8'(MCLK_HALF - 1)) begin
            mcnt_next = 8'h00;
            mclk_next = ~mclk_reg; // RULE1
        end
        rstN_next   = ~resetReq;
        pins_next   = {dblClock, aux1In, aux0In}; // RULE2
        st_next     = st_reg;
        tmr_next    = (tmr_reg != 8'h00) ? tmr_reg - 8'h01 : 8'h00;
        bit_next    = bit_reg;
        isRead_next = isRead_reg;
        csN_next    = csN_reg;
        sclk_next   = sclk_reg;
        din_next    = din_reg;
        tx_next     = tx_reg;
        rx_next     = rx_reg;
        valid_next  = 1'b0;
        case (st_reg)
            H_IDLE: begin
                sclk_next = 1'b1; // RULE14
                // a write is only possible while no word waits, a read only while one does
                if ((readReq && pend) || (writeReq && !pend)) begin
                    isRead_next = readReq && pend;
                    tx_next     = writeByte;
                    csN_next    = 1'b0; // RULE6
                    bit_next    = 5'h00;
                    tmr_next    = 8'(SCLK_HALF - 1);
                    st_next     = H_SETUP;
                end
            end
            H_SETUP, H_HIGH: begin
                if (tmr_reg == 8'h00) begin
                    if (st_reg == H_HIGH) begin
                        rx_next  = {rx_reg[WORD_W-2:0], doutS_reg[1]};
                        tx_next  = {tx_reg[CMD_W-2:0], 1'b0};
                        bit_next = bit_reg + 5'h01;
                    end
                    if (st_reg == H_HIGH && bit_reg == (isRead_reg ? 5'(WORD_W - 1)
                                                                   : 5'(CMD_W - 1))) begin
                        csN_next = 1'b1;
                        tmr_next = 8'(2 * SCLK_HALF - 1);
                        st_next  = H_END;
                    end else begin
                        sclk_next = 1'b0;
                        din_next  = (st_reg == H_HIGH) ? tx_reg[CMD_W-2] : tx_reg[CMD_W-1];
                        tmr_next  = 8'(SCLK_HALF - 1);
                        st_next   = H_LOW;
                    end
                end
            end
            H_LOW: begin
                if (tmr_reg == 8'h00) begin
                    sclk_next = 1'b1;
                    tmr_next  = 8'(SCLK_HALF - 1);
                    st_next   = H_HIGH;
                end
            end
            H_END: begin
                if (tmr_reg == 8'h00) begin
                    valid_next = isRead_reg;
                    st_next    = H_IDLE;
                end
            end
            default: st_next = H_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_reg     <= H_IDLE;
            tmr_reg    <= 8'h00;
            mcnt_reg   <= 8'h00;
            mclk_reg   <= 1'b0;
            bit_reg    <= 5'h00;
            isRead_reg <= 1'b0;
            csN_reg    <= 1'b1;
            sclk_reg   <= 1'b1;
            din_reg    <= 1'b0;
            tx_reg     <= 8'h00;
            rx_reg     <= 16'h0000;
            valid_reg  <= 1'b0;
            rstN_reg   <= 1'b0;
            pins_reg   <= 3'h0;
        end else begin
            st_reg     <= st_next;
            tmr_reg    <= tmr_next;
            mcnt_reg   <= mcnt_next;
            mclk_reg   <= mclk_next;
            bit_reg    <= bit_next;
            isRead_reg <= isRead_next;
            csN_reg    <= csN_next;
            sclk_reg   <= sclk_next;
            din_reg    <= din_next;
            tx_reg     <= tx_next;
            rx_reg     <= rx_next;
            valid_reg  <= valid_next;
            rstN_reg   <= rstN_next;
            pins_reg   <= pins_next;
        end
    end

    assign link.masterClock    = mclk_reg;
    assign link.clockDoubleSel = pins_reg[2];
    assign link.auxStatusIn1   = pins_reg[1];
    assign link.auxStatusIn0   = pins_reg[0];
    assign link.csN            = csN_reg;
    assign link.sclk           = sclk_reg;
    assign link.din            = din_reg;
    assign link.resetN         = rstN_reg;
    assign busy                = csN_reg == 1'b0;
    assign wordPending         = intS_reg[1] == 1'b0;
    assign wordOut             = rx_reg;
    assign wordValid           = valid_reg;
endmodule
`default_nettype wire

/* File: aplc_sva.sv */
`default_nettype none
module aplc_sva (
    input wire logic clk,
    input wire logic rst,
    input wire logic masterClock,
    input wire logic crystalDriveOut,
    input wire logic csN,
    input wire logic sclk,
    input wire logic doutOe,
    input wire logic intN,
    input wire logic resetN
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] riseCnt_reg;
    logic [4:0] riseCnt_next;
    logic       sclkDly_reg;
    // rises of the serial clock inside the current frame
    always_comb begin
        riseCnt_next = riseCnt_reg;
        if (csN) begin
            riseCnt_next = 5'h00;
        end else if (sclk && !sclkDly_reg) begin
            riseCnt_next = riseCnt_reg + 5'h01;
        end
    end
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            riseCnt_reg <= 5'h00;
            sclkDly_reg <= 1'b1;
        end else begin
            riseCnt_reg <= riseCnt_next;
            sclkDly_reg <= sclk;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence frameOpen;
        $fell(csN);
    endsequence
    sequence idleHigh;
        sclk [*3];
    endsequence
    chk_frame_start_idle: assert property (frameOpen |-> idleHigh)
        else $error("serial clock not idle high at frame start");
    chk_sclk_idle_high: assert property (csN |-> sclk)
        else $error("serial clock low outside a frame");
    chk_frame_bit_count: assert property (riseCnt_reg <= 5'h10)
        else $error("more than sixteen clocks in a frame");
    chk_dout_released: assert property (csN [*6] |-> !doutOe)
        else $error("data line driven while deselected");
    chk_reset_state: assert property (!resetN [*8] |-> intN && !doutOe)
        else $error("outputs not at power-on level in reset");
    chk_int_after_read: assert property (
        riseCnt_reg == 5'h0F && $rose(sclk) && !csN && !intN |-> ##[1:10] intN)
        else $error("interrupt not released after full word read");
    chk_xtal_hides_clk: assert property (
        $rose(masterClock) |-> ##[0:5] !crystalDriveOut)
        else $error("crystal drive follows the clock");
    chk_mclk_on_exit: assert property (
        $rose(resetN) |-> ##[1:20] $changed(masterClock))
        else $error("master clock idle at reset release");
endmodule
`default_nettype wire

/* File: testbench.sv */
`default_nettype none
module testbench;
    import aplc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, crystalMode, diffMode, dataValid, resetReq, dblClock;
    logic aux0In, aux1In, readReq, writeReq, dataReady, cmdValid, coreReset;
    logic busy, wordPending, wordValid, modTick;
    logic [CH_W-1:0]    chanSel;
    logic [WORD_W-1:0]  dataIn, wordOut;
    logic [CMD_W-1:0]   writeByte, cmdByte;
    logic [NUM_AIN-1:0] posSel, negSel;
    int                 error_cnt, checked, cycles;
    aplc_if link ();
    aplc_device i_aplc_device (.clk(clk), .rst(rst), .link(link), .crystalMode(crystalMode),
        .diffMode(diffMode), .chanSel(chanSel), .dataIn(dataIn), .dataValid(dataValid),
        .dataReady(dataReady), .posSel(posSel), .negSel(negSel), .cmdByte(cmdByte),
        .cmdValid(cmdValid), .modTick(modTick), .coreReset(coreReset));
    aplc_host i_aplc_host (.clk(clk), .rst(rst), .link(link), .resetReq(resetReq),
        .dblClock(dblClock), .aux0In(aux0In), .aux1In(aux1In), .readReq(readReq),
        .writeReq(writeReq), .writeByte(writeByte), .busy(busy), .wordPending(wordPending),
        .wordOut(wordOut), .wordValid(wordValid));
    aplc_sva i_aplc_sva (.clk(clk), .rst(rst), .masterClock(link.masterClock),
        .crystalDriveOut(link.crystalDriveOut), .csN(link.csN), .sclk(link.sclk),
        .doutOe(link.doutOe), .intN(link.intN), .resetN(link.resetN));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 60000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic tick;
        @(posedge clk);
        #1;
    endtask
    task automatic push(input logic [15:0] w);
        @(negedge clk);
        dataIn = w;
        dataValid = 1'b1;
        // ready is judged at the falling edge, well before the edge that takes the word
        while (dataReady !== 1'b1) @(negedge clk);
        @(negedge clk);
        dataValid = 1'b0;
    endtask
    task automatic t_tick(input int exp);
        int n;
        n = 0;
        repeat (320) begin
            tick();
            n += int'(modTick);
        end
        check("modTick", 16'(n), 16'(exp));
    endtask
    task automatic read(input logic [15:0] w, input logic a1, input logic a0);
        int i;
        @(negedge clk);
        aux1In = a1;
        aux0In = a0;
        readReq = 1'b1;
        for (i = 0; i < 3000 && busy !== 1'b1; i++) tick();
        @(negedge clk);
        readReq = 1'b0;
        // aux levels move after the first fall and must not reach the word
        repeat (16) @(negedge clk);
        {aux1In, aux0In} = ~{a1, a0};
        for (i = 0; i < 600 && wordValid !== 1'b1; i++) tick();
        check("wordOut", wordOut, {w[15:5], a1, a0, w[2:0]});
        // let the synchronised interrupt settle before another frame
        repeat (12) tick();
    endtask
    task automatic wait_exit;
        int i;
        for (i = 0; i < 200 && coreReset !== 1'b0; i++) tick();
        check("coreReset", 16'(coreReset), 16'h0000);
        check("dataReady at exit", 16'(dataReady), 16'h0000);
        tick();
        check("dataReady after exit", 16'(dataReady), 16'h0001);
    endtask
    task automatic t_chan;
        int m, c;
        for (m = 0; m < 2; m++) begin
            for (c = 0; c < 8; c++) begin
                @(negedge clk);
                diffMode = m[0];
                chanSel = c[CH_W-1:0];
                repeat (3) tick();
                if (m == 1) begin
                    check("posSel", 16'(posSel), c < 3 ? 16'h0001 << (2 * c) : 16'h0000);
                    check("negSel", 16'(negSel), c < 3 ? 16'h0002 << (2 * c) : 16'h0000);
                end else begin
                    check("posSel", 16'(posSel), c < 5 ? 16'h0001 << c : 16'h0000);
                    check("negSel", 16'(negSel), c < 5 ? 16'h0020 : 16'h0000);
                end
            end
        end
    endtask
    task automatic t_fill;
        push(16'h1234);
        push(16'hFFE7);
        push(16'h0018);
        repeat (100) tick();
        check("dataReady full", 16'(dataReady), 16'h0000);
        read(16'h1234, 1'b0, 1'b0);
        read(16'hFFE7, 1'b0, 1'b1);
        read(16'h0018, 1'b1, 1'b0);
        check("dataReady drained", 16'(dataReady), 16'h0001);
    endtask
    task automatic t_write(input logic [7:0] b);
        int i;
        @(negedge clk);
        writeByte = b;
        writeReq = 1'b1;
        for (i = 0; i < 200 && busy !== 1'b1; i++) tick();
        @(negedge clk);
        writeReq = 1'b0;
        for (i = 0; i < 400 && cmdValid !== 1'b1; i++) tick();
        check("cmdByte", 16'(cmdByte), 16'(b));
        repeat (12) tick();
    endtask
    task automatic t_xtal;
        @(negedge clk);
        crystalMode = 1'b1;
        repeat (64) tick();
        @(negedge clk);
        crystalMode = 1'b0;
        repeat (6) tick();
        check("crystalDriveOut", 16'(link.crystalDriveOut), 16'h0000);
    endtask
    task automatic t_midreset;
        int i;
        push(16'hC3A5);
        for (i = 0; i < 3000 && wordPending !== 1'b1; i++) tick();
        @(negedge clk);
        resetReq = 1'b1;
        repeat (40) tick();
        check("coreReset held", 16'(coreReset), 16'h0001);
        check("intN in reset", 16'(link.intN), 16'h0001);
        check("wordPending lost", 16'(wordPending), 16'h0000);
        @(negedge clk);
        resetReq = 1'b0;
        dblClock = 1'b1;
        wait_exit();
        t_tick(320 / (4 * MCLK_HALF_CYC));
        push(16'h5A5A);
        read(16'h5A5A, 1'b1, 1'b1);
    endtask
    initial begin
        {rst, crystalMode, diffMode, dataValid, resetReq, dblClock} = 6'h20;
        {aux0In, aux1In, readReq, writeReq} = 4'h0;
        chanSel = 3'h0;
        dataIn = 16'h0000;
        writeByte = 8'h00;
        repeat (16) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        wait_exit();
        t_tick(320 / (2 * MCLK_HALF_CYC));
        t_chan();
        t_fill();
        t_write(8'hA5);
        t_write(8'h3C);
        t_xtal();
        t_midreset();
        conclude();
    end
endmodule
`default_nettype wire
